// *** rtl/page_data_register.sv ***
// Page data register: TCK-sampled TAP follower, byte chain and page buffer sequencer
`timescale 1ns/1ps
`default_nettype none
`include "page_access_cfg.svh"

module page_data_register (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE_N,
    input wire logic PAGE_FILL_INSTRUCTION,
    input wire logic PAGE_DUMP_INSTRUCTION,
    input wire logic [`KEY_BITS-1:0] PROGRAMMING_KEY,
    input wire logic ADDR_LOAD,
    input wire logic [15:0] ADDR_IN,
    output logic MEM_WRITE_REQ,
    output logic MEM_READ_REQ,
    output logic [`ADDR_BITS-1:0] MEM_ADDR,
    output logic MEM_HIGH_BYTE,
    output logic [`DATA_BITS-1:0] MEM_WDATA,
    input wire logic MEM_DONE,
    input wire logic [`DATA_BITS-1:0] MEM_RDATA,
    output logic PROG_ENABLED,
    output logic FILL_OVERRUN
);

    // Two-flop synchronisers for every pin from the programmer's side except ADDR_LOAD and ADDR_IN
    logic tck_s1_reg, tck_s2_reg, tck_d_reg;
    logic tms_s1_reg, tms_s2_reg;
    logic tdi_s1_reg, tdi_s2_reg;
    logic fill_s1_reg, fill_s2_reg;
    logic dump_s1_reg, dump_s2_reg;
    logic [`KEY_BITS-1:0] key_s1_reg, key_s2_reg;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tck_s1_reg <= 1'b0;
            tck_s2_reg <= 1'b0;
            tck_d_reg <= 1'b0;
            tms_s1_reg <= 1'b1;
            tms_s2_reg <= 1'b1;
            tdi_s1_reg <= 1'b0;
            tdi_s2_reg <= 1'b0;
            fill_s1_reg <= 1'b0;
            fill_s2_reg <= 1'b0;
            dump_s1_reg <= 1'b0;
            dump_s2_reg <= 1'b0;
            key_s1_reg <= '0;
            key_s2_reg <= '0;
        end else begin
            tck_s1_reg <= TCK;
            tck_s2_reg <= tck_s1_reg;
            tck_d_reg <= tck_s2_reg;
            tms_s1_reg <= TMS;
            tms_s2_reg <= tms_s1_reg;
            tdi_s1_reg <= TDI;
            tdi_s2_reg <= tdi_s1_reg;
            fill_s1_reg <= PAGE_FILL_INSTRUCTION;
            fill_s2_reg <= fill_s1_reg;
            dump_s1_reg <= PAGE_DUMP_INSTRUCTION;
            dump_s2_reg <= dump_s1_reg;
            key_s1_reg <= PROGRAMMING_KEY;
            key_s2_reg <= key_s1_reg;
        end
    end

    logic tck_rise;
    logic tck_fall;
    assign tck_rise = tck_s2_reg & ~tck_d_reg;
    assign tck_fall = ~tck_s2_reg & tck_d_reg;

    function automatic page_access_pkg::tap_state_t tap_next(input page_access_pkg::tap_state_t s,
                                                              input logic tms);
        unique case (s)
            page_access_pkg::TEST_LOGIC_RESET: tap_next = tms ? page_access_pkg::TEST_LOGIC_RESET
                                                              : page_access_pkg::RUN_TEST_IDLE;
            page_access_pkg::RUN_TEST_IDLE: tap_next = tms ? page_access_pkg::SELECT_DR
                                                           : page_access_pkg::RUN_TEST_IDLE;
            page_access_pkg::SELECT_DR: tap_next = tms ? page_access_pkg::SELECT_IR : page_access_pkg::CAPTURE_DR;
            page_access_pkg::CAPTURE_DR: tap_next = tms ? page_access_pkg::EXIT1_DR : page_access_pkg::SHIFT_DR;
            page_access_pkg::SHIFT_DR: tap_next = tms ? page_access_pkg::EXIT1_DR : page_access_pkg::SHIFT_DR;
            page_access_pkg::EXIT1_DR: tap_next = tms ? page_access_pkg::UPDATE_DR : page_access_pkg::PAUSE_DR;
            page_access_pkg::PAUSE_DR: tap_next = tms ? page_access_pkg::EXIT2_DR : page_access_pkg::PAUSE_DR;
            page_access_pkg::EXIT2_DR: tap_next = tms ? page_access_pkg::UPDATE_DR : page_access_pkg::SHIFT_DR;
            page_access_pkg::UPDATE_DR: tap_next = tms ? page_access_pkg::SELECT_DR
                                                       : page_access_pkg::RUN_TEST_IDLE;
            page_access_pkg::SELECT_IR: tap_next = tms ? page_access_pkg::TEST_LOGIC_RESET
                                                       : page_access_pkg::CAPTURE_IR;
            page_access_pkg::CAPTURE_IR: tap_next = tms ? page_access_pkg::EXIT1_IR : page_access_pkg::SHIFT_IR;
            page_access_pkg::SHIFT_IR: tap_next = tms ? page_access_pkg::EXIT1_IR : page_access_pkg::SHIFT_IR;
            page_access_pkg::EXIT1_IR: tap_next = tms ? page_access_pkg::UPDATE_IR : page_access_pkg::PAUSE_IR;
            page_access_pkg::PAUSE_IR: tap_next = tms ? page_access_pkg::EXIT2_IR : page_access_pkg::PAUSE_IR;
            page_access_pkg::EXIT2_IR: tap_next = tms ? page_access_pkg::UPDATE_IR : page_access_pkg::SHIFT_IR;
            page_access_pkg::UPDATE_IR: tap_next = tms ? page_access_pkg::SELECT_DR
                                                       : page_access_pkg::RUN_TEST_IDLE;
        endcase
    endfunction

    page_access_pkg::tap_state_t tap_reg;
    page_access_pkg::tap_state_t tap_next_val;
    assign tap_next_val = tap_next(tap_reg, tms_s2_reg);

    // The TAP position is followed on sampled TCK edges
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            tap_reg <= page_access_pkg::TEST_LOGIC_RESET;
        end else if (tck_rise) begin
            tap_reg <= tap_next_val; // R8
        end
    end

    logic prog_en;
    logic fill_mode;
    logic dump_mode;
    logic fill_mode_d_reg;
    logic dump_mode_d_reg;
    logic fill_enter;
    logic dump_enter;

    assign prog_en = (key_s2_reg == `KEY_BITS'(`PROGRAMMING_KEY_INSTRUCTION_KEY)); // R11
    assign fill_mode = prog_en & fill_s2_reg & ~dump_s2_reg;
    assign dump_mode = prog_en & dump_s2_reg & ~fill_s2_reg;
    assign fill_enter = fill_mode & ~fill_mode_d_reg;
    assign dump_enter = dump_mode & ~dump_mode_d_reg;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            fill_mode_d_reg <= 1'b0;
            dump_mode_d_reg <= 1'b0;
            PROG_ENABLED <= 1'b0;
        end else begin
            fill_mode_d_reg <= fill_mode;
            dump_mode_d_reg <= dump_mode;
            PROG_ENABLED <= prog_en;
        end
    end

    logic active;
    logic at_capture;
    logic at_shift;
    logic at_update;
    logic entering_capture;
    assign active = fill_mode | dump_mode; // R20
    assign at_capture = active & tck_rise & (tap_reg == page_access_pkg::CAPTURE_DR);
    assign at_shift = active & tck_rise & (tap_reg == page_access_pkg::SHIFT_DR);
    assign at_update = fill_mode & tck_rise & (tap_reg == page_access_pkg::UPDATE_DR);
    assign entering_capture = dump_mode & tck_rise & (tap_next_val == page_access_pkg::CAPTURE_DR);

    logic [`DATA_BITS-1:0] shift_reg;
    logic [`DATA_BITS-1:0] hold_reg;
    logic [`DATA_BITS-1:0] read_buf_reg;
    logic high_byte_reg;
    logic first_byte_reg;
    logic [`ADDR_BITS-1:0] addr_reg;

    // Chain shifts LSB first; only TDI enters while in Shift-DR
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            shift_reg <= `SHIFT_RESET_VALUE;
        end else if (at_capture && dump_mode) begin
            shift_reg <= read_buf_reg; // R5
        end else if (at_shift) begin
            shift_reg <= {tdi_s2_reg, shift_reg[`DATA_BITS-1:1]}; // R1
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            hold_reg <= `SHIFT_RESET_VALUE;
        end else if (at_update) begin
            hold_reg <= shift_reg; // R2
        end
    end

    // Byte toggle and first-byte flag restart whenever a mode is entered
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            high_byte_reg <= 1'b0;
            first_byte_reg <= 1'b1;
        end else if (fill_enter || dump_enter) begin
            high_byte_reg <= 1'b0; // R3 R6
            first_byte_reg <= 1'b1;
        end else if (at_update || (at_capture && dump_mode)) begin
            high_byte_reg <= ~high_byte_reg; // R3 R6
            first_byte_reg <= 1'b0;
        end
    end

    logic fill_pre_inc;
    logic dump_post_inc;
    assign fill_pre_inc = at_update & ~high_byte_reg & ~first_byte_reg;
    assign dump_post_inc = at_capture & dump_mode & high_byte_reg;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            addr_reg <= `ADDR_RESET_VALUE;
        end else if (ADDR_LOAD) begin
            addr_reg <= ADDR_IN[`PROGRAM_ADDR_TOP_BIT:0]; // R17
        end else if (fill_pre_inc) begin
            addr_reg <= addr_reg + 1'b1; // R4
        end else if (dump_post_inc) begin
            addr_reg <= addr_reg + 1'b1; // R7
        end
    end

    // Page-buffer writes queue here; a slow memory drops bytes only once the 8-deep queue is full (FILL_OVERRUN)
    logic pend_reg;
    logic [`FIFO_WIDTH-1:0] pend_data_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [`FIFO_WIDTH-1:0] fifo_out_data;
    logic [`ADDR_BITS-1:0] write_addr;
    assign write_addr = fill_pre_inc ? addr_reg + 1'b1 : addr_reg;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pend_reg <= 1'b0;
            pend_data_reg <= '0;
            FILL_OVERRUN <= 1'b0;
        end else begin
            if (at_update) begin
                pend_reg <= 1'b1; // R2
                pend_data_reg <= {write_addr, high_byte_reg, shift_reg};
                FILL_OVERRUN <= pend_reg & ~fifo_in_ready;
            end else if (fifo_in_ready) begin
                pend_reg <= 1'b0;
            end
        end
    end

    page_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) write_queue (
        .clk(MCLK),
        .rst_n(RST_N),
        .in_valid(pend_reg),
        .in_ready(fifo_in_ready),
        .in_data(pend_data_reg),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    page_access_pkg::mem_state_t mem_state_reg;
    assign fifo_out_ready = (mem_state_reg == page_access_pkg::MEM_IDLE) & ~entering_capture;

    // Writes win over reads only when no capture is imminent; a read fetched
    // on entry to Capture-DR lands well before the capture edge at 64 ns TCK
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            mem_state_reg <= page_access_pkg::MEM_IDLE;
            MEM_WRITE_REQ <= 1'b0;
            MEM_READ_REQ <= 1'b0;
            MEM_ADDR <= `ADDR_RESET_VALUE;
            MEM_HIGH_BYTE <= 1'b0;
            MEM_WDATA <= `SHIFT_RESET_VALUE;
            read_buf_reg <= `SHIFT_RESET_VALUE;
        end else begin
            unique case (mem_state_reg)
                page_access_pkg::MEM_IDLE: begin
                    if (entering_capture) begin
                        mem_state_reg <= page_access_pkg::MEM_READ;
                        MEM_READ_REQ <= 1'b1; // R8
                        MEM_ADDR <= addr_reg;
                        MEM_HIGH_BYTE <= high_byte_reg;
                    end else if (fifo_out_valid) begin
                        mem_state_reg <= page_access_pkg::MEM_WRITE;
                        MEM_WRITE_REQ <= 1'b1; // R2 R8
                        MEM_ADDR <= fifo_out_data[`FIFO_WIDTH-1:`DATA_BITS+1];
                        MEM_HIGH_BYTE <= fifo_out_data[`DATA_BITS];
                        MEM_WDATA <= fifo_out_data[`DATA_BITS-1:0];
                    end
                end
                page_access_pkg::MEM_WRITE: begin
                    if (MEM_DONE) begin
                        mem_state_reg <= page_access_pkg::MEM_IDLE; // R8
                        MEM_WRITE_REQ <= 1'b0;
                    end
                end
                page_access_pkg::MEM_READ: begin
                    if (MEM_DONE) begin
                        mem_state_reg <= page_access_pkg::MEM_IDLE; // R8
                        MEM_READ_REQ <= 1'b0;
                        read_buf_reg <= MEM_RDATA;
                    end
                end
                default: begin
                    mem_state_reg <= page_access_pkg::MEM_IDLE;
                    MEM_WRITE_REQ <= 1'b0;
                    MEM_READ_REQ <= 1'b0;
                end
            endcase
        end
    end

    // TDO changes on the falling TCK edge so the programmer samples it stable
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            TDO <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else if (tck_fall) begin
            TDO <= shift_reg[0];
            TDO_OE_N <= ~(active & (tap_reg == page_access_pkg::SHIFT_DR)); // R20
        end
    end

endmodule

`default_nettype wire

// *** include/page_access_cfg.svh ***
// Constants for the page data register and its flash sequencing
// What this block and its programmer must do
// R1 - Eight-bit shift chain plus eight-bit holding register
// R2 - Update copies chain, starts write within 11 TCK
// R3 - Load updates alternate low/high, low first
// R4 - Address pre-increments before low byte, not first
// R5 - Read mode captures addressed byte at Capture-DR
// R6 - Read captures alternate low/high, low first
// R7 - Address post-increments after every high-byte read
// R8 - Test-clock state machine drives memory, watches strobes
// R9 - Programmer idles so updates are 11 TCK apart
// R10 - Programmer holds core reset before programming entry
// R11 - Programming enabled only with exact 16-bit key
// R12 - Exit: no-operation command, then zero key
// R13 - Final exit step releases core reset
// R14 - Chip erase by command, then poll or wait
// R15 - Programmer erases chip before programming pages
// R16 - Word programming: enable, address, data, page write
// R17 - Address bits above top valid bit ignored
// R18 - Programmer loads word-in-page address as zero
// R19 - Programmer repeats poll until status reads one
// R20 - Data register active only in fill/dump instruction
`ifndef PAGE_ACCESS_CFG_SVH
`define PAGE_ACCESS_CFG_SVH

`define DATA_BITS 8
`define PROGRAM_ADDR_TOP_BIT 14
`define ADDR_BITS 15
`define KEY_BITS 16
`define PROGRAMMING_KEY_INSTRUCTION_KEY 16'hA370
`define FIFO_DEPTH 8
`define FIFO_WIDTH 24
`define WRITE_LIMIT_TCK 11
`define SHIFT_RESET_VALUE 8'h00
`define ADDR_RESET_VALUE 15'h0000

`endif

// *** include/page_access_pkg.sv ***
// Types shared by the page data register logic
package page_access_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'h0,
        RUN_TEST_IDLE = 4'h1,
        SELECT_DR = 4'h2,
        CAPTURE_DR = 4'h3,
        SHIFT_DR = 4'h4,
        EXIT1_DR = 4'h5,
        PAUSE_DR = 4'h6,
        EXIT2_DR = 4'h7,
        UPDATE_DR = 4'h8,
        SELECT_IR = 4'h9,
        CAPTURE_IR = 4'hA,
        SHIFT_IR = 4'hB,
        EXIT1_IR = 4'hC,
        PAUSE_IR = 4'hD,
        EXIT2_IR = 4'hE,
        UPDATE_IR = 4'hF
    } tap_state_t;

    typedef enum logic [1:0] {
        MEM_IDLE = 2'b00,
        MEM_WRITE = 2'b01,
        MEM_READ = 2'b10
    } mem_state_t;

endpackage

// *** rtl/page_fifo.sv ***
// Small FIFO between the page data register and the page buffer port
`timescale 1ns/1ps
`default_nettype none

module page_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_BITS = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_BITS-1:0] wr_ptr_reg;
    logic [PTR_BITS-1:0] rd_ptr_reg;
    logic [PTR_BITS:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (PTR_BITS+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // Storage is registered, so the head word is read straight from a flop
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_BITS'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_BITS'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (PTR_BITS+1)'(push) - (PTR_BITS+1)'(pop);
        end
    end

endmodule

`default_nettype wire

// *** tb/flash_buffer_model.sv ***
// Behavioural page buffer and flash array answering the memory port
`timescale 1ns/1ps
`default_nettype none

module flash_buffer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic wr_req,
    input wire logic rd_req,
    input wire logic [14:0] addr,
    input wire logic high_byte,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:255];
    logic [1:0] wait_reg;
    int lat_seed = 32'h9f0f;

    // Latency varies 1..3 cycles; stall holds the answer off to back up the FIFO
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done <= 1'b0;
            wait_reg <= 2'h0;
            rdata <= 8'h00;
        end else if ((wr_req || rd_req) && !done && !stall && wait_reg == 2'h0) begin
            done <= 1'b1;
            rdata <= mem[{addr[6:0], high_byte}];
            if (wr_req) begin
                mem[{addr[6:0], high_byte}] <= wdata;
            end
            wait_reg <= 2'($random(lat_seed));
        end else begin
            done <= 1'b0;
            // Read data is only meaningful beside done, so it keeps moving otherwise
            rdata <= ~rdata;
            if ((wr_req || rd_req) && !stall && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/page_data_register_sva.sv ***
// Concurrent checks on the page data register ports
`timescale 1ns/1ps
`default_nettype none
`include "page_access_cfg.svh"

module page_data_register_sva (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic TCK,
    input wire logic TDO,
    input wire logic TDO_OE_N,
    input wire logic PAGE_FILL_INSTRUCTION,
    input wire logic PAGE_DUMP_INSTRUCTION,
    input wire logic [`KEY_BITS-1:0] PROGRAMMING_KEY,
    input wire logic MEM_WRITE_REQ,
    input wire logic MEM_READ_REQ,
    input wire logic [`ADDR_BITS-1:0] MEM_ADDR,
    input wire logic MEM_HIGH_BYTE,
    input wire logic [`DATA_BITS-1:0] MEM_WDATA,
    input wire logic MEM_DONE,
    input wire logic PROG_ENABLED
);
    default clocking main_clk @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_write_done_drop: assert property (MEM_WRITE_REQ && MEM_DONE |=> !MEM_WRITE_REQ)
        else $error("Write request outlived its completion");
    a_read_done_drop: assert property (MEM_READ_REQ && MEM_DONE |=> !MEM_READ_REQ)
        else $error("Read request outlived its completion");
    a_write_holds: assert property (MEM_WRITE_REQ && !MEM_DONE |=> MEM_WRITE_REQ && $stable(MEM_ADDR)
        && $stable(MEM_WDATA) && $stable(MEM_HIGH_BYTE))
        else $error("Write request moved before completion");
    a_read_holds: assert property (MEM_READ_REQ && !MEM_DONE |=> MEM_READ_REQ && $stable(MEM_ADDR)
        && $stable(MEM_HIGH_BYTE))
        else $error("Read request moved before completion");
    a_single_access: assert property (!(MEM_WRITE_REQ && MEM_READ_REQ))
        else $error("Read and write requested together");
    a_access_keyed: assert property ($rose(MEM_WRITE_REQ) || $rose(MEM_READ_REQ) |-> PROG_ENABLED)
        else $error("Memory access without programming enabled");
    a_key_match: assert property ($stable(PROGRAMMING_KEY) [*6] |->
        PROG_ENABLED == (PROGRAMMING_KEY == `PROGRAMMING_KEY_INSTRUCTION_KEY))
        else $error("Programming enable does not follow the key");
    a_read_dump_only: assert property ($rose(MEM_READ_REQ) |-> PAGE_DUMP_INSTRUCTION && !PAGE_FILL_INSTRUCTION)
        else $error("Read started outside dump mode");
    a_drive_gated: assert property (!TDO_OE_N |-> PROG_ENABLED && (PAGE_FILL_INSTRUCTION ^ PAGE_DUMP_INSTRUCTION))
        else $error("TDO driven while the register is inactive");
    a_tdo_on_fall: assert property ($changed(TDO) || $changed(TDO_OE_N) |-> !TCK)
        else $error("TDO moved while TCK high");
endmodule

bind page_data_register page_data_register_sva page_data_register_sva_inst (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .TCK(TCK),
    .TDO(TDO),
    .TDO_OE_N(TDO_OE_N),
    .PAGE_FILL_INSTRUCTION(PAGE_FILL_INSTRUCTION),
    .PAGE_DUMP_INSTRUCTION(PAGE_DUMP_INSTRUCTION),
    .PROGRAMMING_KEY(PROGRAMMING_KEY),
    .MEM_WRITE_REQ(MEM_WRITE_REQ),
    .MEM_READ_REQ(MEM_READ_REQ),
    .MEM_ADDR(MEM_ADDR),
    .MEM_HIGH_BYTE(MEM_HIGH_BYTE),
    .MEM_WDATA(MEM_WDATA),
    .MEM_DONE(MEM_DONE),
    .PROG_ENABLED(PROG_ENABLED)
);

`default_nettype wire

// *** tb/page_data_register_test.sv ***
// Self-checking bench for the page data register
`timescale 1ns/1ps
`default_nettype none
`include "page_access_cfg.svh"

module page_data_register_test;
    logic MCLK, RST_N, TCK, TMS, TDI, TDO, TDO_OE_N, ADDR_LOAD, MEM_DONE;
    logic PAGE_FILL_INSTRUCTION, PAGE_DUMP_INSTRUCTION, MEM_WRITE_REQ, MEM_READ_REQ;
    logic MEM_HIGH_BYTE, PROG_ENABLED, FILL_OVERRUN, stall, mute, wr_seen, rd_seen;
    logic [`KEY_BITS-1:0] PROGRAMMING_KEY;
    logic [15:0] ADDR_IN;
    logic [`ADDR_BITS-1:0] MEM_ADDR;
    logic [`DATA_BITS-1:0] MEM_WDATA, MEM_RDATA;
    logic [24:0] notes[$];
    logic [7:0] bytes[$];
    int n_errors, tests_run, seed;

    page_data_register page_data_register_inst (.MCLK(MCLK), .RST_N(RST_N), .TCK(TCK), .TMS(TMS), .TDI(TDI),
        .TDO(TDO), .TDO_OE_N(TDO_OE_N), .PAGE_FILL_INSTRUCTION(PAGE_FILL_INSTRUCTION),
        .PAGE_DUMP_INSTRUCTION(PAGE_DUMP_INSTRUCTION), .PROGRAMMING_KEY(PROGRAMMING_KEY),
        .ADDR_LOAD(ADDR_LOAD), .ADDR_IN(ADDR_IN), .MEM_WRITE_REQ(MEM_WRITE_REQ), .MEM_READ_REQ(MEM_READ_REQ),
        .MEM_ADDR(MEM_ADDR), .MEM_HIGH_BYTE(MEM_HIGH_BYTE), .MEM_WDATA(MEM_WDATA), .MEM_DONE(MEM_DONE),
        .MEM_RDATA(MEM_RDATA), .PROG_ENABLED(PROG_ENABLED), .FILL_OVERRUN(FILL_OVERRUN));

    flash_buffer_model flash_buffer_model_inst (.clk(MCLK), .rst_n(RST_N), .stall(stall),
        .wr_req(MEM_WRITE_REQ), .rd_req(MEM_READ_REQ), .addr(MEM_ADDR), .high_byte(MEM_HIGH_BYTE),
        .wdata(MEM_WDATA), .done(MEM_DONE), .rdata(MEM_RDATA));

    initial begin
        MCLK = 1'b0;
        forever #2.5 MCLK = ~MCLK;
    end

    task automatic close_out;
        $display("Counts: %0d compares, %0d mismatches", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [24:0] exp, input logic [24:0] act);
        tests_run++;
        if (exp !== act) begin
            n_errors++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask

    // Each request that opens on the memory port while mute is low is matched with the oldest note
    always @(negedge MCLK) begin
        wr_seen <= MEM_WRITE_REQ;
        rd_seen <= MEM_READ_REQ;
        if (RST_N && !mute && ((MEM_WRITE_REQ && !wr_seen) || (MEM_READ_REQ && !rd_seen))) begin
            check(notes.size() == 0 ? 25'h1ff_ffff : notes.pop_front(), {MEM_WRITE_REQ, MEM_ADDR, MEM_HIGH_BYTE,
                MEM_WRITE_REQ ? MEM_WDATA : 8'h00});
        end
    end

    // TCK is launched off the MCLK grid so its edges never meet a sampling edge
    task automatic tck(input logic ms, input logic di, output logic dout);
        TMS = ms;
        TDI = di;
        #32;
        dout = TDO;
        TCK = 1'b1;
        #32;
        TCK = 1'b0;
    endtask

    task automatic dr(input logic [7:0] din, output logic [7:0] dout, output logic oe);
        logic o;
        @(negedge MCLK);
        #0.3;
        tck(1'b1, 1'b0, o);
        tck(1'b0, 1'b0, o);
        tck(1'b0, 1'b0, o);
        for (int i = 0; i < 8; i++) begin
            tck(i == 7, din[i], o);
            dout[i] = o;
            if (i == 3) begin
                oe = TDO_OE_N;
            end
        end
        tck(1'b1, 1'b0, o);
        tck(1'b0, 1'b0, o);
    endtask

    task automatic mode(input logic fill_on, input logic dump_on);
        @(negedge MCLK);
        PAGE_FILL_INSTRUCTION = fill_on;
        PAGE_DUMP_INSTRUCTION = dump_on;
        repeat (6) @(negedge MCLK);
    endtask

    task automatic load_addr(input logic [15:0] a);
        @(negedge MCLK);
        ADDR_IN = a;
        ADDR_LOAD = 1'b1;
        @(negedge MCLK);
        ADDR_LOAD = 1'b0;
    endtask

    task automatic set_key(input logic [15:0] k);
        @(negedge MCLK);
        PROGRAMMING_KEY = k;
        repeat (6) @(negedge MCLK);
    endtask

    // Eight bits per update keep thirteen TCKs between updates
    task automatic fill(input int n, input logic [14:0] base, input logic expect_wr, input logic oe_exp);
        logic [7:0] b, d;
        logic oe;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            if (expect_wr) begin
                notes.push_back({1'b1, base + 15'(i / 2), i[0], b});
            end
            bytes.push_back(b);
            dr(b, d, oe);
            check(25'(oe_exp), 25'(oe));
        end
    endtask

    task automatic dump(input int n, input logic [14:0] base);
        logic [7:0] d;
        logic oe;
        for (int i = 0; i < n; i++) begin
            notes.push_back({1'b0, base + 15'(i / 2), i[0], 8'h00});
            dr(8'h00, d, oe);
            check(25'(bytes[i]), 25'(d));
            check(25'h0, 25'(oe));
        end
    endtask

    task automatic drain;
        int idle = 0;
        for (int i = 0; i < 2000 && idle < 16; i++) begin
            @(negedge MCLK);
            idle = (MEM_WRITE_REQ || MEM_READ_REQ) ? 0 : idle + 1;
        end
        if (idle < 16 || notes.size() != 0) begin
            n_errors++;
            $display("MISMATCH t=%0t pending=%h idle=%h", $time, notes.size(), idle);
            close_out;
        end
    endtask

    initial begin
        logic o;
        seed = 32'h9f0f;
        n_errors = 0;
        tests_run = 0;
        {RST_N, TCK, TMS, TDI, ADDR_LOAD, stall, mute, wr_seen, rd_seen} = 9'h020;
        {PAGE_FILL_INSTRUCTION, PAGE_DUMP_INSTRUCTION} = 2'b00;
        PROGRAMMING_KEY = 16'h0000;
        ADDR_IN = 16'h0000;
        repeat (12) @(negedge MCLK);
        RST_N = 1'b1;
        check(25'h10, 25'({TDO, TDO_OE_N, MEM_WRITE_REQ, MEM_READ_REQ, PROG_ENABLED, FILL_OVERRUN}));
        repeat (4) @(negedge MCLK);
        #0.3;
        repeat (5) tck(1'b1, 1'b0, o);
        tck(1'b0, 1'b0, o);
        $display("Test reset done");
        set_key(16'hA371);
        check(25'h0, 25'(PROG_ENABLED));
        mode(1'b1, 1'b0);
        load_addr(16'h0010);
        fill(2, 15'h0010, 1'b0, 1'b1);
        mode(1'b0, 1'b0);
        drain;
        $display("Test wrong key done");
        // Core hold step precedes the key on the real link
        set_key(`PROGRAMMING_KEY_INSTRUCTION_KEY);
        check(25'h1, 25'(PROG_ENABLED));
        load_addr(16'h8010);
        bytes.delete();
        mode(1'b1, 1'b0);
        // Array treated as freshly erased; burst stands in for word-wise loads
        fill(6, 15'h0010, 1'b1, 1'b0);
        mode(1'b0, 1'b0);
        // Draining until idle plays the programmer's completion poll
        drain;
        $display("Test page fill done");
        load_addr(16'h0010);
        mode(1'b0, 1'b1);
        dump(6, 15'h0010);
        mode(1'b0, 1'b0);
        drain;
        $display("Test page dump done");
        load_addr(16'h0020);
        stall = 1'b1;
        mode(1'b1, 1'b0);
        fill(9, 15'h0020, 1'b1, 1'b0);
        check(25'h0, 25'(FILL_OVERRUN));
        stall = 1'b0;
        drain;
        mode(1'b0, 1'b0);
        $display("Test buffer near full done");
        mute = 1'b1;
        stall = 1'b1;
        mode(1'b1, 1'b0);
        fill(12, 15'h0030, 1'b0, 1'b0);
        check(25'h1, 25'(FILL_OVERRUN));
        stall = 1'b0;
        drain;
        mode(1'b0, 1'b0);
        mute = 1'b0;
        $display("Test buffer overrun done");
        set_key(16'h0000);
        check(25'h0, 25'(PROG_ENABLED));
        $display("Test exit done");
        close_out;
    end
endmodule

`default_nettype wire
